// File: core/gpsc_top.sv
/*
 * Pin routing, pin output drive, status reports and switching-ramp
 * phase and spread control registers.
 * Assumes a register engine on the core clock that presents a byte
 * address with one-cycle read and write strobes; status inputs come
 * from logic on the same clock.
 */
`timescale 1ns/10ps
`include "gpsc_consts.svh"
module gpsc_top #(
    parameter logic [7:0] SILICON_ID = 8'h5a,   // arbitrary value
    parameter int         RAMP_DIV   = `GPSC_RAMP_DIV
) (
    input  wire logic       core_clk_in,        // core clock
    input  wire logic       sys_rst_in,         // sync reset
    input  wire logic [7:0] reg_addr_in,        // register offset
    input  wire logic       reg_wr_in,          // write strobe
    input  wire logic       reg_rd_in,          // read strobe
    input  wire logic [7:0] reg_wdata_in,       // write data
    output logic      [7:0] reg_rdata_out,      // read data
    input  wire logic [2:0] gp_pin_in,          // pin input levels
    output logic      [2:0] gp_pin_out,         // pin drive levels
    output logic      [2:0] gp_pin_oe_out,      // pin drive enables
    input  wire logic [2:0] pin_direction_in,   // 1 output, 0 input
    input  wire logic [1:0] power_state_code_in, // power state
    input  wire logic       left_auto_muted_in,  // left muted
    input  wire logic       right_auto_muted_in, // right muted
    input  wire logic       internal_sync_in,   // internal sync pulse
    input  wire logic [2:0] random_spread_range_in, // range code
    input  wire logic       fsw_576_in,         // 1 = 576k switching
    output logic            sync_input_out,     // routed sync input
    output logic            reset_input_out,    // routed reset input
    output logic            third_input_out,    // routed third input
    output logic            ramp_clk_out,       // phased ramp clock
    output logic            random_spread_enable_out,   // random ss
    output logic            triangle_spread_enable_out, // triangle ss
    output logic [2:0]      random_spread_range_out,    // range used
    output logic            random_range_ok_out // range code legal
);

    // ****************************************************************
    // registers
    // ****************************************************************
    gpsc_pkg::gpsc_route_t sync_input_pin_select_r;
    gpsc_pkg::gpsc_route_t reset_input_pin_select_r;
    gpsc_pkg::gpsc_route_t third_input_pin_select_r;
    logic [2:0] pin_output_levels_r;
    logic [2:0] pin_output_invert_bits_r;
    logic [1:0] switching_phase_offset_r;
    logic       phase_sync_source_r;
    logic       phase_sync_enable_r;
    logic       random_spread_enable_r;
    logic       triangle_spread_enable_r;
    logic [2:0] pin_level;
    logic       sync_pin_prev_r;
    logic       sync_pulse;
    logic [7:0] rd_mux;

    initial
    begin
        if (RAMP_DIV % `GPSC_PHASE_STEPS != 0)
            $error("gpsc_top: RAMP_DIV must be a multiple of 8");
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            sync_input_pin_select_r  <= gpsc_pkg::GPSC_ROUTE_NONE;
            reset_input_pin_select_r <= gpsc_pkg::GPSC_ROUTE_NONE;
            third_input_pin_select_r <= gpsc_pkg::GPSC_ROUTE_NONE;
        end
        else if (reg_wr_in && reg_addr_in == `GPSC_ADDR_ROUTE)
        begin
            sync_input_pin_select_r <= gpsc_pkg::gpsc_route_t'(
                reg_wdata_in[`GPSC_SYNC_SEL_LSB+1 -: 2]);
            reset_input_pin_select_r <= gpsc_pkg::gpsc_route_t'(
                reg_wdata_in[`GPSC_RST_SEL_LSB+1 -: 2]);
            third_input_pin_select_r <= gpsc_pkg::gpsc_route_t'(
                reg_wdata_in[`GPSC_THIRD_SEL_LSB+1 -: 2]);
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            pin_output_levels_r <= `GPSC_RESET_3B;
        else if (reg_wr_in && reg_addr_in == `GPSC_ADDR_LEVELS)
            pin_output_levels_r <= reg_wdata_in[2:0];
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            pin_output_invert_bits_r <= `GPSC_RESET_3B;
        else if (reg_wr_in && reg_addr_in == `GPSC_ADDR_INVERT)
            pin_output_invert_bits_r <= reg_wdata_in[2:0];
    end

    // phase takes effect at once; staging it before play is up to
    // the host, so a change mid-play shifts the ramp audibly
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            switching_phase_offset_r <= 2'h0;
            phase_sync_source_r      <= 1'b0;
            phase_sync_enable_r      <= 1'b0;
        end
        else if (reg_wr_in && reg_addr_in == `GPSC_ADDR_PHASE)
        begin
            switching_phase_offset_r <=
                reg_wdata_in[`GPSC_PHASE_OFS_LSB+1 -: 2];
            phase_sync_source_r <= reg_wdata_in[`GPSC_SYNC_SRC_BIT];
            phase_sync_enable_r <= reg_wdata_in[`GPSC_SYNC_EN_BIT];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            random_spread_enable_r   <= 1'b0;
            triangle_spread_enable_r <= 1'b0;
        end
        else if (reg_wr_in && reg_addr_in == `GPSC_ADDR_SPREAD)
        begin
            random_spread_enable_r <=
                reg_wdata_in[`GPSC_RANDOM_EN_BIT];
            triangle_spread_enable_r <=
                reg_wdata_in[`GPSC_TRI_EN_BIT];
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    always_comb
    begin
        case (reg_addr_in)
            `GPSC_ADDR_ROUTE:   rd_mux = {2'h0, sync_input_pin_select_r,
                                          reset_input_pin_select_r,
                                          third_input_pin_select_r};
            `GPSC_ADDR_LEVELS:  rd_mux = {5'h0, pin_output_levels_r};
            `GPSC_ADDR_INVERT:  rd_mux = {5'h0, pin_output_invert_bits_r};
            `GPSC_ADDR_SILICON: rd_mux = SILICON_ID;
            `GPSC_ADDR_POWER:   rd_mux = {6'h0, power_state_code_in};
            `GPSC_ADDR_MUTE:    rd_mux = {6'h0, right_auto_muted_in,
                                          left_auto_muted_in};
            `GPSC_ADDR_PHASE:   rd_mux = {4'h0, switching_phase_offset_r,
                                          phase_sync_source_r,
                                          phase_sync_enable_r};
            `GPSC_ADDR_SPREAD:  rd_mux = {6'h0, random_spread_enable_r,
                                          triangle_spread_enable_r};
            default:            rd_mux = `GPSC_RESET_BYTE;
        endcase
    end

    // status is sampled at the read strobe, not held from an older one
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= `GPSC_RESET_BYTE;
        else if (reg_rd_in)
            reg_rdata_out <= rd_mux;
    end

    // ****************************************************************
    // pins
    // ****************************************************************
    gpsc_pin_sync #(
        .WIDTH      (3)
    ) u_pin_sync (
        .core_clk_in(core_clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (gp_pin_in),
        .level_out  (pin_level)
    );

    function automatic logic route_pick(
        input gpsc_pkg::gpsc_route_t sel,
        input logic [2:0]            lvl
    );
        case (sel)
            gpsc_pkg::GPSC_ROUTE_PIN0: route_pick = lvl[0];
            gpsc_pkg::GPSC_ROUTE_PIN1: route_pick = lvl[1];
            gpsc_pkg::GPSC_ROUTE_PIN2: route_pick = lvl[2];
            default:                   route_pick = 1'b0;
        endcase
    endfunction

    // an output-configured pin still feeds its own level back
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            sync_input_out  <= 1'b0;
            reset_input_out <= 1'b0;
            third_input_out <= 1'b0;
        end
        else
        begin
            sync_input_out  <= route_pick(sync_input_pin_select_r,
                                          pin_level);
            reset_input_out <= route_pick(reset_input_pin_select_r,
                                          pin_level);
            third_input_out <= route_pick(third_input_pin_select_r,
                                          pin_level);
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            gp_pin_out    <= 3'h0;
            gp_pin_oe_out <= 3'h0;
        end
        else
        begin
            gp_pin_out    <= pin_output_levels_r
                           ^ pin_output_invert_bits_r;
            gp_pin_oe_out <= pin_direction_in;
        end
    end

    // ****************************************************************
    // ramp sync and spread
    // ****************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            sync_pin_prev_r <= 1'b0;
        else
            sync_pin_prev_r <= sync_input_out;
    end

    assign sync_pulse = phase_sync_enable_r
        & (phase_sync_source_r ? internal_sync_in
                               : (sync_input_out & ~sync_pin_prev_r));

    gpsc_ramp_phase #(
        .DIV            (RAMP_DIV)
    ) u_ramp (
        .core_clk_in    (core_clk_in),
        .sys_rst_in     (sys_rst_in),
        .phase_in       (switching_phase_offset_r),
        .sync_pulse_in  (sync_pulse),
        .ramp_clk_out   (ramp_clk_out)
    );

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            random_spread_enable_out   <= 1'b0;
            triangle_spread_enable_out <= 1'b0;
            random_spread_range_out    <= 3'h0;
            random_range_ok_out        <= 1'b0;
        end
        else
        begin
            random_spread_enable_out   <= random_spread_enable_r;
            triangle_spread_enable_out <= triangle_spread_enable_r;
            random_spread_range_out    <= random_spread_range_in;
            case (random_spread_range_in)
                3'h0, 3'h2, 3'h3, 3'h4: random_range_ok_out <= 1'b1;
                3'h5:    random_range_ok_out <= ~fsw_576_in;
                default: random_range_ok_out <= 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_route_none_low: assert property (
        sync_input_pin_select_r == gpsc_pkg::GPSC_ROUTE_NONE
        |=> !sync_input_out)
    else $error("unrouted sync input not low");

    a_route_pin_two: assert property (
        reset_input_pin_select_r == gpsc_pkg::GPSC_ROUTE_PIN2
        |=> reset_input_out == $past(pin_level[2]))
    else $error("reset input not taken from pin two");

    a_level_write_drive: assert property (
        reg_wr_in && reg_addr_in == `GPSC_ADDR_LEVELS
        ##1 !(reg_wr_in && reg_addr_in == `GPSC_ADDR_INVERT)
        |=> gp_pin_out == ($past(reg_wdata_in[2:0], 2)
                           ^ $past(pin_output_invert_bits_r)))
    else $error("pin drive does not follow written levels");

    a_invert_after_reset: assert property (
        $fell(sys_rst_in) |-> pin_output_invert_bits_r == 3'h0
                              && phase_sync_enable_r == 1'b0)
    else $error("invert or sync enable not clear after reset");

    a_power_readback: assert property (
        reg_rd_in && reg_addr_in == `GPSC_ADDR_POWER
        |=> reg_rdata_out == {6'h0, $past(power_state_code_in)})
    else $error("power state read mismatch");

    a_mute_readback: assert property (
        reg_rd_in && reg_addr_in == `GPSC_ADDR_MUTE
        |=> reg_rdata_out[1] == $past(right_auto_muted_in)
            && reg_rdata_out[0] == $past(left_auto_muted_in)
            && reg_rdata_out[7:2] == 6'h0)
    else $error("auto-mute read mismatch");

    a_sync_off_quiet: assert property (
        !phase_sync_enable_r && u_ramp.cnt_r != u_ramp.LAST
        |=> u_ramp.cnt_r == $past(u_ramp.cnt_r) + 1'b1)
    else $error("ramp sync while disabled");

    a_sync_pin_source: assert property (
        phase_sync_enable_r && !phase_sync_source_r
        && $rose(sync_input_out) |=> u_ramp.cnt_r == '0)
    else $error("pin sync edge not used");

    a_spread_write: assert property (
        reg_wr_in && reg_addr_in == `GPSC_ADDR_SPREAD
        |=> ##1 random_spread_enable_out == $past(reg_wdata_in[1], 2)
            && triangle_spread_enable_out == $past(reg_wdata_in[0], 2))
    else $error("spread enables do not follow write");

    a_direction_drive: assert property (
        ##1 gp_pin_oe_out == $past(pin_direction_in))
    else $error("pin enable does not follow direction");

    a_range_reserved: assert property (
        fsw_576_in && random_spread_range_in == 3'h5
        |=> !random_range_ok_out)
    else $error("reserved range accepted at 576k");

    c_play_read: cover property (
        reg_rd_in && reg_addr_in == `GPSC_ADDR_POWER
        && power_state_code_in == gpsc_pkg::GPSC_PWR_PLAY);
    c_pin_sync: cover property (sync_pulse && !phase_sync_source_r);
    c_invert_drive: cover property (
        |(gp_pin_oe_out & pin_output_invert_bits_r));

endmodule

// File: core/gpsc_consts.svh
/*
 * Register map, field positions and reset values of the pin routing,
 * status report and switching-ramp control group.
 * Assumes a register engine that presents byte address and byte data.
 */
`ifndef GPSC_CONSTS_SVH
`define GPSC_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define GPSC_ADDR_ROUTE     8'h64
`define GPSC_ADDR_LEVELS    8'h65
`define GPSC_ADDR_INVERT    8'h66
`define GPSC_ADDR_SILICON   8'h67
`define GPSC_ADDR_POWER     8'h68
`define GPSC_ADDR_MUTE      8'h69
`define GPSC_ADDR_PHASE     8'h6a
`define GPSC_ADDR_SPREAD    8'h6b

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define GPSC_SYNC_SEL_LSB   4
`define GPSC_RST_SEL_LSB    2
`define GPSC_THIRD_SEL_LSB  0
`define GPSC_PHASE_OFS_LSB  2
`define GPSC_SYNC_SRC_BIT   1
`define GPSC_SYNC_EN_BIT    0
`define GPSC_RANDOM_EN_BIT  1
`define GPSC_TRI_EN_BIT     0
`define GPSC_RESET_BYTE     8'h00
`define GPSC_RESET_3B       3'h0

// ****************************************************************
// ramp timing
// ****************************************************************
`define GPSC_RAMP_DIV       264
`define GPSC_PHASE_STEPS    8

`endif

// File: core/gpsc_pkg.sv
/*
 * Types shared by the pin routing and ramp control group.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpsc_pkg;

    typedef enum logic [1:0]
    {
        GPSC_ROUTE_NONE = 2'h0,
        GPSC_ROUTE_PIN0 = 2'h1,
        GPSC_ROUTE_PIN1 = 2'h2,
        GPSC_ROUTE_PIN2 = 2'h3
    } gpsc_route_t;

    typedef enum logic [1:0]
    {
        GPSC_PWR_DEEP_SLEEP = 2'h0,
        GPSC_PWR_SLEEP      = 2'h1,
        GPSC_PWR_HIZ        = 2'h2,
        GPSC_PWR_PLAY       = 2'h3
    } gpsc_power_t;

endpackage

// File: core/gpsc_pin_sync.sv
/*
 * Three-stage synchroniser for the general-purpose pin inputs.
 * Assumes asynchronous pin levels; a change is accepted once the
 * second and third stages agree.
 */
`timescale 1ns/10ps
module gpsc_pin_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             core_clk_in,  // core clock
    input  wire logic             sys_rst_in,   // sync reset
    input  wire logic [WIDTH-1:0] pin_in,       // raw pin levels
    output logic      [WIDTH-1:0] level_out     // accepted levels
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    initial
    begin
        if (WIDTH < 1)
            $error("gpsc_pin_sync: WIDTH must be at least one");
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            meta_r <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
        end
        else
        begin
            meta_r <= pin_in;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
        end
    end

    // per bit: filters a one-cycle glitch that slips past stage two
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_accept
        always_ff @(posedge core_clk_in)
        begin
            if (sys_rst_in)
                level_out[i] <= 1'b0;
            else if (s2_r[i] == s3_r[i])
                level_out[i] <= s3_r[i];
        end
    end

endmodule

// File: core/gpsc_ramp_phase.sv
/*
 * Switching-ramp clock with selectable phase offset and restart.
 * Assumes the sync pulse is one core cycle wide and already gated
 * by the enable and source selection.
 */
`timescale 1ns/10ps
`include "gpsc_consts.svh"
module gpsc_ramp_phase #(
    parameter int DIV = `GPSC_RAMP_DIV
) (
    input  wire logic       core_clk_in,    // core clock
    input  wire logic       sys_rst_in,     // sync reset
    input  wire logic [1:0] phase_in,       // offset code
    input  wire logic       sync_pulse_in,  // restart request
    output logic            ramp_clk_out    // phased ramp clock
);

    localparam int W = $clog2(DIV) + 1;
    localparam int STEPS = `GPSC_PHASE_STEPS;
    localparam logic [W-1:0] STEP  = W'(DIV / STEPS);
    localparam logic [W-1:0] LAST  = W'(DIV - 1);
    localparam logic [W-1:0] HALF  = W'(DIV / 2);
    localparam logic [W-1:0] DIVW  = W'(DIV);

    logic [W-1:0] cnt_r;
    logic [W-1:0] ofs;
    logic [W:0]   sum;
    logic [W-1:0] shifted;
    logic [W-1:0] rise_pt;

    initial
    begin
        if (DIV < 16 || (DIV % STEPS) != 0)
            $error("gpsc_ramp_phase: DIV must be a multiple of 8, >= 16");
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            cnt_r <= '0;
        else if (sync_pulse_in)
            cnt_r <= '0;
        else if (cnt_r == LAST)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + W'(1);
    end

    // 45 degrees is one eighth of the period
    always_comb
    begin
        ofs = W'(STEP * W'(phase_in));
        sum = {1'b0, cnt_r} + {1'b0, ofs};
        if (sum >= {1'b0, DIVW})
            shifted = W'(sum - {1'b0, DIVW});
        else
            shifted = sum[W-1:0];
        rise_pt = (ofs == '0) ? LAST : W'(DIVW - ofs - W'(1));
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            ramp_clk_out <= 1'b0;
        else
            ramp_clk_out <= (shifted < HALF);
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_phase_rise_point: assert property (
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !sync_pulse_in && cnt_r == rise_pt
        ##1 !sync_pulse_in && $stable(phase_in)
        |=> ramp_clk_out && !$past(ramp_clk_out))
    else $error("ramp rise not at phase offset point");

    a_sync_restart: assert property (
        @(posedge core_clk_in) disable iff (sys_rst_in)
        sync_pulse_in |=> cnt_r == '0)
    else $error("ramp counter not restarted by sync");

endmodule

// File: dv/gpsc_host.sv
/*
 * Host model for the byte register port of the pin and ramp group.
 * Assumes strobes taken on the rising edge and read data one cycle later.
 */
`timescale 1ns/10ps
module gpsc_host (
    input  wire logic       clk_in,    // core clock
    input  wire logic [7:0] rdata_in,  // read data
    output logic      [7:0] addr_out,  // register offset
    output logic            wr_out,    // write strobe
    output logic            rd_out,    // read strobe
    output logic      [7:0] wdata_out  // write data
);
    // ****************************************************************
    // register cycles
    // ****************************************************************
    // phase is written in t_ramp while the power state input is left at play
    // one device only, so ramp and spread settings match
    initial
    begin
        {addr_out, wr_out, rd_out, wdata_out} = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        wdata_out = ~d;  // stale data must not pass for valid
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule

// File: dv/gpsc_top_test.sv
/*
 * Self-checking bench for the pin routing and ramp control group.
 * Assumes the host model for register traffic and a 16-cycle ramp.
 */
`timescale 1ns/10ps
module gpsc_top_test;
    localparam logic [7:0] OK384 = 8'h3d;
    localparam logic [7:0] OK576 = 8'h1d;
    logic       core_clk_in;
    logic       sys_rst_in;
    logic [7:0] addr, wdata, rdata, d;
    logic       wr, rd, lm, rm, isync, fsw, so, ro, to, rclk, ren, ten, rok;
    logic [2:0] pin, pin_o, oe, dir, rng, rng_o;
    logic [1:0] pwr;
    int         n_fail, compares;

    gpsc_top #(.SILICON_ID(8'h3c), .RAMP_DIV(16)) dut (
        .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .gp_pin_in(pin),
        .gp_pin_out(pin_o), .gp_pin_oe_out(oe), .pin_direction_in(dir),
        .power_state_code_in(pwr), .left_auto_muted_in(lm),
        .right_auto_muted_in(rm), .internal_sync_in(isync),
        .random_spread_range_in(rng), .fsw_576_in(fsw),
        .sync_input_out(so), .reset_input_out(ro), .third_input_out(to),
        .ramp_clk_out(rclk), .random_spread_enable_out(ren),
        .triangle_spread_enable_out(ten),
        .random_spread_range_out(rng_o), .random_range_ok_out(rok));

    gpsc_host host (.clk_in(core_clk_in), .rdata_in(rdata), .addr_out(addr),
        .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic results;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    // cycles until the ramp clock is next seen to fall
    task automatic fall_after(output int n);
        logic p;
        n = 0;
        p = rclk;
        while (!(p && !rclk))
        begin
            p = rclk;
            cyc(1);
            n++;
            if (n > 40)
            begin
                n_fail++;
                results();
            end
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        for (int a = 8'h64; a <= 8'h6c; a++)
        begin
            host.rd(8'(a), d);
            chk(d, a == 8'h67 ? 8'h3c : 8'h00);
        end
        $display("t_reset done");
    endtask

    task automatic t_pins;
        dir = 3'b111;
        host.wr(8'h65, 8'hff);
        cyc(3);
        chk(8'(pin_o), 8'h07);
        host.rd(8'h65, d);
        chk(d, 8'h07);
        host.wr(8'h66, 8'h05);
        cyc(3);
        chk(8'(pin_o), 8'h02);
        host.rd(8'h66, d);
        chk(d, 8'h05);
        dir = 3'b010;
        cyc(2);
        chk(8'(oe), 8'h02);
        $display("t_pins done");
    endtask

    task automatic t_route;
        dir = 3'b000;
        for (int p = 0; p < 4; p++)
        begin
            host.wr(8'h64, 8'(p * 8'h15));
            pin = (p == 0) ? 3'b111 : 3'(1 << (p - 1));
            cyc(7);
            chk(8'({so, ro, to}), p == 0 ? 8'h0 : 8'h7);
            pin = ~pin;
            cyc(7);
            chk(8'({so, ro, to}), 8'h0);
        end
        host.wr(8'h64, 8'h1b);
        pin = 3'b001;
        cyc(7);
        chk(8'({so, ro, to}), 8'h4);
        $display("t_route done");
    endtask

    task automatic t_status;
        for (int c = 0; c < 4; c++)
        begin
            pwr = 2'(c);
            {rm, lm} = 2'(c);
            host.rd(8'h68, d);
            chk(d, 8'(c));
            host.rd(8'h69, d);
            chk(d, 8'(c));
        end
        host.wr(8'h68, 8'h00);
        host.rd(8'h68, d);
        chk(d, 8'h03);
        $display("t_status done");
    endtask

    task automatic t_spread;
        for (int c = 0; c < 4; c++)
        begin
            host.wr(8'h6b, 8'(c) | 8'hfc);
            cyc(3);
            chk(8'({ren, ten}), 8'(c));
            host.rd(8'h6b, d);
            chk(d, 8'(c));
        end
        for (int c = 0; c < 16; c++)
        begin
            {fsw, rng} = 4'(c);
            cyc(2);
            chk(8'(rng_o), 8'(c % 8));
            chk(8'(rok), 8'(c < 8 ? OK384[c % 8] : OK576[c % 8]));
        end
        $display("t_spread done");
    endtask

    task automatic t_ramp;
        int n0;
        int n;
        for (int p = 0; p < 4; p++)
        begin
            host.wr(8'h6a, 8'(p * 4 + 3));
            isync = 1'b1;
            cyc(1);
            isync = 1'b0;
            fall_after(n);
            if (p == 0)
                n0 = n;
            chk(8'(n), 8'(n0 - 2 * p));
        end
        fall_after(n);
        chk(8'(n), 8'd16);
        // disabled, then pin-sourced: the internal pulse must not restart
        for (int k = 0; k < 2; k++)
        begin
            host.wr(8'h6a, k == 0 ? 8'h0e : 8'h0d);
            isync = 1'b1;
            cyc(1);
            isync = 1'b0;
            fall_after(n);
            chk(8'(n), 8'd13);
        end
        // pin-sourced restart: a rising pin edge cuts the period short
        pin = 3'b000;
        fall_after(n);
        chk(8'(n), 8'd16);
        pin = 3'b001;
        fall_after(n);
        chk(8'(n), 8'd9);
        $display("t_ramp done");
    endtask

    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    initial
    begin
        {pin, dir, pwr, lm, rm, isync, rng, fsw} = '0;
        sys_rst_in = 1'b1;
        repeat (5) @(posedge core_clk_in);
        #1;
        sys_rst_in = 1'b0;
        t_reset();
        t_pins();
        t_route();
        t_status();
        t_spread();
        t_ramp();
        results();
    end
endmodule
